// [core/qwe_dev.sv]
// Flash-side QPI decoder for write enable and status read instructions.
//
// What this block and the host controller do
// R1 - Every byte takes two clocks on four lines
// R2 - Decode 06h, 50h, 04h as single-byte instructions
// R3 - Wrap read takes length from parameter low nibble
// R4 - Host sends continuation byte with upper nibble ones
// R5 - 06h sets the write enable latch
// R6 - Writes need latch; rejected while latch clear
// R7 - Host frames 06h alone between chip select edges
// R8 - 50h leaves latch clear, arms volatile status write
// R9 - 04h clears the write enable latch
// R10 - Latch clears at reset and operation completion
// R11 - 04h also cancels a pending volatile arm
// R12 - 05h/35h shift status out, falling edges, MSB first
// R13 - Two eight-bit status registers with listed bits
// R14 - Status reads accepted even while busy
// R15 - Status repeats until chip select rises
// R16 - Quad enable stays set; writes refused in QPI
// R17 - Resets restore non-volatile status values
// R18 - High nibble first, line 3 carries MSB
// R19 - Partial opcode ignored, latch unchanged
`timescale 1ns/100ps
`include "qwe_consts.svh"
module qwe_dev (
	input wire logic mclk,
	input wire logic reset,
	qwe_link_if.dev link,
	input wire logic busy_in,
	input wire logic suspend_in,
	input wire logic op_done,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic cmd_reject,
	output logic [3:0] wrap_length_field,
	output logic [7:0] read_parameter_byte,
	output logic write_enable_latch,
	output logic quad_enable_bit
);
	logic [2:0] cs_sh, ck_sh;
	logic [3:0] io_s1, io_s2, io_s3;
	logic cs_q, ck_q, ck_rise, ck_fall, cs_fall, cs_rise;
	qwe_pkg::qwe_dev_state_t state_reg;
	logic nib_half_reg, out_half_reg, arm_reg, rst_en_reg, io_oe_reg;
	logic [3:0] nib_hi_reg, io_out_reg;
	logic [7:0] byte_now, opcode_reg, arg_reg, out_byte_reg;
	logic [1:0] argc_reg;
	logic [7:0] sr1_nv_reg, sr2_nv_reg, sr1_vol_reg, sr2_vol_reg;
	logic exec0, exec1, soft_rst, wr_nv, wr_vol, is_write_op;
	logic [7:0] sr1_view, sr2_view, sr2_next;

	// Three-stage sampling; a level counts once stages two and three agree.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cs_sh <= 3'h7;
			ck_sh <= 3'h0;
			io_s1 <= 4'hf;
			io_s2 <= 4'hf;
			io_s3 <= 4'hf;
			cs_q <= 1'b1;
			ck_q <= 1'b0;
		end
		else
		begin
			cs_sh <= {cs_sh[1:0], link.cs_n};
			ck_sh <= {ck_sh[1:0], link.sclk};
			io_s1 <= link.io;
			io_s2 <= io_s1;
			io_s3 <= io_s2;
			if (cs_sh[1] == cs_sh[2])
				cs_q <= cs_sh[2];
			if (ck_sh[1] == ck_sh[2])
				ck_q <= ck_sh[2];
		end
	end

	assign ck_rise = ck_sh[1] & ck_sh[2] & ~ck_q & ~cs_q;
	assign ck_fall = ~ck_sh[1] & ~ck_sh[2] & ck_q & ~cs_q;
	assign cs_fall = ~cs_sh[1] & ~cs_sh[2] & cs_q;
	assign cs_rise = cs_sh[1] & cs_sh[2] & ~cs_q;
	assign byte_now = {nib_hi_reg, io_s3}; // R18
	assign is_write_op = opcode_reg inside {`QWE_OP_PP, `QWE_OP_QPP, `QWE_OP_SE, `QWE_OP_BE32,
		`QWE_OP_BE64, `QWE_OP_CE1, `QWE_OP_CE2, `QWE_OP_SECER, `QWE_OP_SECPR};
	// Instructions act at chip select rise, and only on whole bytes.
	assign exec0 = cs_rise && state_reg == qwe_pkg::QWE_D_ARG && argc_reg == 2'h0
		&& !nib_half_reg; // R2 R19
	assign exec1 = cs_rise && state_reg == qwe_pkg::QWE_D_ARG && argc_reg == 2'h1
		&& !nib_half_reg;
	assign soft_rst = exec0 && opcode_reg == `QWE_OP_RST && rst_en_reg;
	assign wr_nv = exec1 && write_enable_latch
		&& (opcode_reg == `QWE_OP_WRSR1 || opcode_reg == `QWE_OP_WRSR2); // R6
	assign wr_vol = exec1 && !write_enable_latch && arm_reg
		&& (opcode_reg == `QWE_OP_WRSR1 || opcode_reg == `QWE_OP_WRSR2); // R8

	// Framing: opcode, then argument bytes, or status out.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_reg <= qwe_pkg::QWE_D_IDLE;
			nib_half_reg <= 1'b0;
			nib_hi_reg <= 4'h0;
			opcode_reg <= 8'h00;
			arg_reg <= 8'h00;
			argc_reg <= 2'h0;
		end
		else if (cs_rise)
			state_reg <= qwe_pkg::QWE_D_IDLE;
		else if (cs_fall)
		begin
			state_reg <= qwe_pkg::QWE_D_CMD;
			nib_half_reg <= 1'b0;
			argc_reg <= 2'h0;
		end
		else if (ck_rise && state_reg != qwe_pkg::QWE_D_OUT)
		begin
			nib_half_reg <= ~nib_half_reg; // R1
			if (!nib_half_reg)
				nib_hi_reg <= io_s3;
			else if (state_reg == qwe_pkg::QWE_D_CMD)
			begin
				opcode_reg <= byte_now;
				if (byte_now == `QWE_OP_RDSR1 || byte_now == `QWE_OP_RDSR2) // R14
					state_reg <= qwe_pkg::QWE_D_OUT;
				else
					state_reg <= qwe_pkg::QWE_D_ARG;
			end
			else
			begin
				if (argc_reg == 2'h0)
					arg_reg <= byte_now;
				if (argc_reg != 2'h3)
					argc_reg <= argc_reg + 2'h1;
			end
		end
	end
	// Status bits as read; busy and suspend come live from the engine.
	assign sr1_view = {sr1_vol_reg[7:2], write_enable_latch, busy_in}; // R13
	assign sr2_view = {suspend_in, sr2_vol_reg[6:0]};
	// Shift status out on falling edges, repeating the byte while clocks run.
	always_ff @(posedge mclk)
	begin
		if (reset || cs_rise || cs_fall)
		begin
			out_half_reg <= 1'b0;
			out_byte_reg <= 8'h00;
			io_out_reg <= 4'h0;
			io_oe_reg <= 1'b0;
		end
		else if (ck_fall && state_reg == qwe_pkg::QWE_D_OUT)
		begin
			io_oe_reg <= 1'b1;
			out_half_reg <= ~out_half_reg; // R15
			if (!out_half_reg)
			begin
				out_byte_reg <= (opcode_reg == `QWE_OP_RDSR1) ? sr1_view : sr2_view;
				io_out_reg <= (opcode_reg == `QWE_OP_RDSR1) ? sr1_view[7:4] : sr2_view[7:4]; // R12
			end
			else
				io_out_reg <= out_byte_reg[3:0]; // R18
		end
	end

	assign link.dev_io_out = io_out_reg;
	assign link.dev_io_oe = {4{io_oe_reg}};

	// Write enable latch; a set in the same cycle as a clear wins.
	always_ff @(posedge mclk)
	begin
		if (reset)
			write_enable_latch <= 1'b0; // R10
		else if (exec0 && opcode_reg == `QWE_OP_WREN)
			write_enable_latch <= 1'b1; // R5
		else if ((exec0 && opcode_reg == `QWE_OP_WRDIS) || op_done || wr_nv || soft_rst)
			write_enable_latch <= 1'b0; // R9 R10
	end

	// Volatile write arm and the reset-enable step.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			arm_reg <= 1'b0;
			rst_en_reg <= 1'b0;
		end
		else
		begin
			if (exec0 && opcode_reg == `QWE_OP_VWREN)
				arm_reg <= 1'b1; // R8
			else if ((exec0 && opcode_reg == `QWE_OP_WRDIS) || wr_vol || soft_rst)
				arm_reg <= 1'b0; // R11
			if (exec0 || exec1)
				rst_en_reg <= exec0 && opcode_reg == `QWE_OP_RSTEN;
		end
	end

	// Lock bits only ever set; quad enable cannot change in four-bit mode.
	always_comb
	begin
		sr2_next = sr2_vol_reg;
		sr2_next[`QWE_BIT_COMPL] = arg_reg[`QWE_BIT_COMPL];
		sr2_next[`QWE_BIT_LOCK] = arg_reg[`QWE_BIT_LOCK] | sr2_vol_reg[`QWE_BIT_LOCK];
		sr2_next[`QWE_OTP_MSB:`QWE_OTP_LSB] = arg_reg[`QWE_OTP_MSB:`QWE_OTP_LSB]
			| sr2_vol_reg[`QWE_OTP_MSB:`QWE_OTP_LSB];
		sr2_next[`QWE_BIT_QUAD] = sr2_vol_reg[`QWE_BIT_QUAD]; // R16
		sr2_next[`QWE_BIT_SUSP] = 1'b0;
	end
	// Non-volatile and volatile status copies.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sr1_nv_reg <= `QWE_SR1_NV_RESET;
			sr2_nv_reg <= `QWE_SR2_NV_RESET;
			sr1_vol_reg <= `QWE_SR1_NV_RESET;
			sr2_vol_reg <= `QWE_SR2_NV_RESET;
		end
		else if (soft_rst)
		begin
			sr1_vol_reg <= sr1_nv_reg; // R17
			sr2_vol_reg <= sr2_nv_reg;
		end
		else if (wr_nv || wr_vol)
		begin
			if (opcode_reg == `QWE_OP_WRSR1)
			begin
				sr1_vol_reg <= {arg_reg[7:2], 2'h0};
				if (wr_nv)
					sr1_nv_reg <= {arg_reg[7:2], 2'h0};
			end
			else
			begin
				sr2_vol_reg <= sr2_next;
				if (wr_nv)
					sr2_nv_reg <= sr2_next;
			end
		end
	end

	assign quad_enable_bit = sr2_vol_reg[`QWE_BIT_QUAD];
	// Read parameters, wrap length, and handoff of write-class opcodes.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			read_parameter_byte <= `QWE_PARAM_RESET;
			wrap_length_field <= 4'h0;
			cmd_valid <= 1'b0;
			cmd_reject <= 1'b0;
			cmd_opcode <= 8'h00;
		end
		else
		begin
			if (exec1 && opcode_reg == `QWE_OP_SETPAR)
				read_parameter_byte <= arg_reg;
			if (state_reg == qwe_pkg::QWE_D_ARG && opcode_reg == `QWE_OP_WRAPRD)
				wrap_length_field <= read_parameter_byte[3:0]; // R3
			cmd_valid <= 1'b0;
			cmd_reject <= 1'b0;
			if (cs_rise && state_reg == qwe_pkg::QWE_D_ARG && !nib_half_reg && is_write_op)
			begin
				cmd_opcode <= opcode_reg;
				cmd_valid <= write_enable_latch; // R6
				cmd_reject <= !write_enable_latch;
			end
		end
	end
endmodule : qwe_dev

// [core/qwe_consts.svh]
// Opcodes, status bit positions, reset values and timing counts of the QPI command link.
`ifndef QWE_CONSTS_SVH
`define QWE_CONSTS_SVH
`define QWE_OP_WREN 8'h06
`define QWE_OP_VWREN 8'h50
`define QWE_OP_WRDIS 8'h04
`define QWE_OP_RDSR1 8'h05
`define QWE_OP_RDSR2 8'h35
`define QWE_OP_WRSR1 8'h01
`define QWE_OP_WRSR2 8'h31
`define QWE_OP_SETPAR 8'hc0
`define QWE_OP_WRAPRD 8'h0c
`define QWE_OP_QIORD 8'heb
`define QWE_OP_PP 8'h02
`define QWE_OP_QPP 8'h32
`define QWE_OP_SE 8'h20
`define QWE_OP_BE32 8'h52
`define QWE_OP_BE64 8'hd8
`define QWE_OP_CE1 8'hc7
`define QWE_OP_CE2 8'h60
`define QWE_OP_SECER 8'h44
`define QWE_OP_SECPR 8'h42
`define QWE_OP_RSTEN 8'h66
`define QWE_OP_RST 8'h99
`define QWE_MODE_NIB_HI 4'hf
`define QWE_NIB_PER_BYTE 2
`define QWE_BIT_BUSY 0
`define QWE_BIT_LATCH 1
`define QWE_SR1_WR_LSB 2
`define QWE_BIT_LOCK 0
`define QWE_BIT_QUAD 1
`define QWE_OTP_LSB 2
`define QWE_OTP_MSB 5
`define QWE_BIT_COMPL 6
`define QWE_BIT_SUSP 7
`define QWE_SR1_NV_RESET 8'h00
`define QWE_SR2_NV_RESET 8'h02
`define QWE_PARAM_RESET 8'h00
`define QWE_HALF_NS 500
`define QWE_CLK_NS 50
`define QWE_HALF_CYC ((`QWE_HALF_NS + `QWE_CLK_NS - 1) / `QWE_CLK_NS)
`endif

// [core/qwe_pkg.sv]
// Types shared by both ends of the QPI command link.
package qwe_pkg;
	typedef enum logic [3:0] {
		QWE_D_IDLE = 4'h1,
		QWE_D_CMD = 4'h2,
		QWE_D_ARG = 4'h4,
		QWE_D_OUT = 4'h8
	} qwe_dev_state_t;
	typedef enum logic [4:0] {
		QWE_H_IDLE = 5'h01,
		QWE_H_LOW = 5'h02,
		QWE_H_HIGH = 5'h04,
		QWE_H_TAIL = 5'h08,
		QWE_H_GAP = 5'h10
	} qwe_host_state_t;
endpackage : qwe_pkg

// [core/qwe_link_if.sv]
// Four-bit link between host controller and flash command decoder.
`timescale 1ns/100ps
interface qwe_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_io_out;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_out;
	logic [3:0] dev_io_oe;
	logic [3:0] io;
	// An undriven line reads high, as through a pull-up.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			io[i] = dev_io_oe[i] ? dev_io_out[i] : (host_io_oe[i] ? host_io_out[i] : 1'b1);
	end
	modport host (
		output cs_n,
		output sclk,
		output host_io_out,
		output host_io_oe,
		input io
	);
	modport dev (
		input cs_n,
		input sclk,
		input io,
		output dev_io_out,
		output dev_io_oe
	);
endinterface : qwe_link_if

// [core/qwe_host.sv]
// Host-side QPI controller that frames one instruction per start request.
`timescale 1ns/100ps
`include "qwe_consts.svh"
module qwe_host #(
	parameter int HALF = `QWE_HALF_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	qwe_link_if.host link,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [2:0] tx_count,
	input wire logic [31:0] tx_data,
	input wire logic [3:0] rx_count,
	output logic busy,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic done
);
	qwe_pkg::qwe_host_state_t state_reg;
	logic [15:0] div_reg;
	logic [39:0] tx_sh_reg;
	logic [4:0] nib_reg;
	logic [4:0] tx_nibs_reg;
	logic [4:0] last_reg;
	logic [3:0] rx_hi_reg;
	logic [3:0] io_s1;
	logic [3:0] io_s2;
	logic [3:0] io_s3;
	logic [31:0] tx_fixed;
	logic cs_n_reg;
	logic sclk_reg;
	logic [3:0] io_out_reg;
	logic io_oe_reg;
	logic div_end;

	assign div_end = div_reg == 16'(HALF - 1);

	// The continuation byte of a quad I/O read is the fourth byte after the opcode,
	// so it sits in the low byte of the data word; its upper nibble is forced to ones.
	always_comb
	begin
		tx_fixed = tx_data;
		if (opcode == `QWE_OP_QIORD)
			tx_fixed[7:4] = `QWE_MODE_NIB_HI; // R4
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			io_s1 <= 4'hf;
			io_s2 <= 4'hf;
			io_s3 <= 4'hf;
		end
		else
		begin
			io_s1 <= link.io;
			io_s2 <= io_s1;
			io_s3 <= io_s2;
		end
	end

	// Clock divider and frame sequencer; data changes on falling edges.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_reg <= qwe_pkg::QWE_H_IDLE;
			div_reg <= 16'h0000;
			tx_sh_reg <= 40'h0;
			nib_reg <= 5'h00;
			tx_nibs_reg <= 5'h00;
			last_reg <= 5'h00;
			rx_hi_reg <= 4'h0;
			cs_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			io_out_reg <= 4'h0;
			io_oe_reg <= 1'b0;
			busy <= 1'b0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			rx_valid <= 1'b0;
			done <= 1'b0;
			div_reg <= div_end ? 16'h0000 : div_reg + 16'h0001;
			case (state_reg)
				qwe_pkg::QWE_H_IDLE:
				begin
					div_reg <= 16'h0000;
					if (start)
					begin
						busy <= 1'b1;
						cs_n_reg <= 1'b0; // R7
						tx_sh_reg <= {opcode, tx_fixed} << 4;
						io_out_reg <= opcode[7:4]; // R18
						io_oe_reg <= 1'b1;
						nib_reg <= 5'h00;
						tx_nibs_reg <= 5'(`QWE_NIB_PER_BYTE * (tx_count + 3'h1)); // R1
						last_reg <= 5'(`QWE_NIB_PER_BYTE * (tx_count + 3'h1 + rx_count) - 1);
						state_reg <= qwe_pkg::QWE_H_LOW;
					end
				end
				qwe_pkg::QWE_H_LOW:
					if (div_end)
					begin
						sclk_reg <= 1'b1;
						if (nib_reg >= tx_nibs_reg)
						begin
							rx_hi_reg <= io_s3;
							if (nib_reg[0])
							begin
								rx_data <= {rx_hi_reg, io_s3};
								rx_valid <= 1'b1;
							end
						end
						state_reg <= qwe_pkg::QWE_H_HIGH;
					end
				qwe_pkg::QWE_H_HIGH:
					if (div_end)
					begin
						sclk_reg <= 1'b0;
						if (nib_reg == last_reg)
						begin
							io_oe_reg <= 1'b0;
							state_reg <= qwe_pkg::QWE_H_TAIL;
						end
						else
						begin
							nib_reg <= nib_reg + 5'h01;
							io_out_reg <= tx_sh_reg[39:36];
							tx_sh_reg <= tx_sh_reg << 4;
							io_oe_reg <= (nib_reg + 5'h01) < tx_nibs_reg;
							state_reg <= qwe_pkg::QWE_H_LOW;
						end
					end
				qwe_pkg::QWE_H_TAIL:
					if (div_end)
					begin
						cs_n_reg <= 1'b1;
						state_reg <= qwe_pkg::QWE_H_GAP;
					end
				qwe_pkg::QWE_H_GAP:
					if (div_end)
					begin
						busy <= 1'b0;
						done <= 1'b1;
						state_reg <= qwe_pkg::QWE_H_IDLE;
					end
				default:
					state_reg <= qwe_pkg::QWE_H_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.sclk = sclk_reg;
	assign link.host_io_out = io_out_reg;
	assign link.host_io_oe = {4{io_oe_reg}};
endmodule : qwe_host

// [testbench/qwe_props.sv]
// Assertions on the four-bit link between host controller and flash decoder.
`timescale 1ns/100ps
module qwe_props #(
	parameter int HALF = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] io
);
	logic [7:0] high_reg;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// Counts the high phase of the link clock so its length can be checked.
	always_ff @(posedge mclk)
	begin
		if (reset || !sclk)
			high_reg <= 8'h00;
		else
			high_reg <= high_reg + 8'h01;
	end
	a_oe_exclusive: assert property (!((host_io_oe != 4'h0) && (dev_io_oe != 4'h0)))
		else $error("host and device drive the lines together");
	a_oe_whole: assert property ((host_io_oe inside {4'h0, 4'hf})
		&& (dev_io_oe inside {4'h0, 4'hf}))
		else $error("link lines not driven as one group");
	a_sclk_framed: assert property ($changed(sclk) |-> !cs_n)
		else $error("link clock moved outside a frame");
	a_idle_low: assert property (cs_n |-> !sclk)
		else $error("link clock high while deselected");
	a_half_len: assert property ($fell(sclk) |-> high_reg == 8'(HALF))
		else $error("link clock high phase has wrong length");
	a_io_settled: assert property (sclk && $past(sclk) && !cs_n |-> $stable(io))
		else $error("data lines moved while link clock high");
	a_dev_quiet: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*8])
		else $error("device drove during opcode phase");
	a_dev_release: assert property ($rose(cs_n) |-> ##[1:6] (dev_io_oe == 4'h0))
		else $error("device kept driving after deselect");
endmodule : qwe_props

// [testbench/testbench.sv]
// Self-checking bench joining host controller and flash decoder over the link.
`timescale 1ns/100ps
module testbench;
	localparam int HALF = 8;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [2:0] tx_count = 3'h0;
	logic [31:0] tx_data = 32'h0;
	logic [3:0] rx_count = 4'h0;
	logic busy_in = 1'b0;
	logic suspend_in = 1'b0;
	logic op_done = 1'b0;
	logic busy, rx_valid, done, cmd_valid, cmd_reject, write_enable_latch, quad_enable_bit;
	logic [7:0] rx_data, cmd_opcode, read_parameter_byte;
	logic [3:0] wrap_length_field;
	logic [15:0] rx_reg;
	logic [7:0] wire_reg;
	logic [7:0] wops [9] = '{8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h44, 8'h42};
	int num_errors = 0, compares = 0, cycles = 0, nval = 0, nrej = 0, nrise = 0;
	qwe_link_if link ();
	qwe_host #(.HALF(HALF)) qwe_host_inst (.mclk(mclk), .reset(reset), .link(link),
		.start(start), .opcode(opcode), .tx_count(tx_count), .tx_data(tx_data),
		.rx_count(rx_count), .busy(busy), .rx_data(rx_data), .rx_valid(rx_valid), .done(done));
	qwe_dev qwe_dev_inst (.mclk(mclk), .reset(reset), .link(link), .busy_in(busy_in),
		.suspend_in(suspend_in), .op_done(op_done), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_reject(cmd_reject), .wrap_length_field(wrap_length_field),
		.read_parameter_byte(read_parameter_byte), .write_enable_latch(write_enable_latch),
		.quad_enable_bit(quad_enable_bit));
	qwe_props #(.HALF(HALF)) qwe_props_inst (.mclk(mclk), .reset(reset), .cs_n(link.cs_n),
		.sclk(link.sclk), .host_io_oe(link.host_io_oe), .dev_io_oe(link.dev_io_oe), .io(link.io));
	initial
	begin
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (rx_valid)
			rx_reg <= {rx_reg[7:0], rx_data};
		if (cmd_valid)
			nval++;
		if (cmd_reject)
			nrej++;
		if (cycles == 20000)
		begin
			num_errors++;
			close_out();
		end
	end
	// The wire is watched independently of both ends, so a shared slip cannot hide.
	always @(posedge link.sclk)
	begin
		wire_reg <= {wire_reg[3:0], link.io};
		nrise++;
	end
	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task xfer(input logic [7:0] op, input logic [2:0] n, input logic [31:0] d,
		input logic [3:0] rn);
		int k;
		@(posedge mclk);
		opcode <= op;
		tx_count <= n;
		tx_data <= d;
		rx_count <= rn;
		start <= 1'b1;
		nrise = 0;
		@(posedge mclk);
		start <= 1'b0;
		@(posedge mclk);
		check("busy", busy, 16'h1);
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			@(posedge mclk);
			k++;
		end
		if (k == 3000)
			num_errors++;
		check("busy", busy, 16'h0);
		// The decoder acts a few cycles after deselect, so let that settle.
		repeat (6) @(posedge mclk);
	endtask : xfer
	task close_out();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		check("latch", write_enable_latch, 16'h0);
		check("quad", quad_enable_bit, 16'h1);
		xfer(8'h05, 3'h0, 32'h0, 4'h1);
		check("sr1", rx_reg[7:0], 16'h00);
		suspend_in <= 1'b1;
		xfer(8'h35, 3'h0, 32'h0, 4'h1);
		check("sr2", rx_reg[7:0], 16'h82);
		xfer(8'h06, 3'h1, 32'h0, 4'h0);
		check("latch", write_enable_latch, 16'h0);
		xfer(8'h06, 3'h0, 32'h0, 4'h0);
		check("wire", wire_reg, 16'h06);
		check("clocks", 16'(nrise), 16'h2);
		check("latch", write_enable_latch, 16'h1);
		xfer(8'h04, 3'h0, 32'h0, 4'h0);
		check("latch", write_enable_latch, 16'h0);
		xfer(8'h50, 3'h0, 32'h0, 4'h0);
		check("latch", write_enable_latch, 16'h0);
		foreach (wops[i])
			xfer(wops[i], 3'h3, 32'h0, 4'h0);
		check("rejects", 16'(nrej), 16'h9);
		xfer(8'h06, 3'h0, 32'h0, 4'h0);
		xfer(8'h20, 3'h3, 32'h00123000, 4'h0);
		check("accepts", 16'(nval), 16'h1);
		check("cmd", cmd_opcode, 16'h20);
		busy_in <= 1'b1;
		xfer(8'h05, 3'h0, 32'h0, 4'h2);
		check("poll", rx_reg, 16'h0303);
		busy_in <= 1'b0;
		op_done <= 1'b1;
		@(posedge mclk);
		op_done <= 1'b0;
		repeat (2) @(posedge mclk);
		check("latch", write_enable_latch, 16'h0);
		xfer(8'h06, 3'h0, 32'h0, 4'h0);
		xfer(8'h01, 3'h1, 32'h1c000000, 4'h0);
		check("latch", write_enable_latch, 16'h0);
		xfer(8'h50, 3'h0, 32'h0, 4'h0);
		xfer(8'h01, 3'h1, 32'h08000000, 4'h0);
		xfer(8'h05, 3'h0, 32'h0, 4'h1);
		check("sr1", rx_reg[7:0], 16'h08);
		xfer(8'h50, 3'h0, 32'h0, 4'h0);
		xfer(8'h04, 3'h0, 32'h0, 4'h0);
		xfer(8'h01, 3'h1, 32'h0, 4'h0);
		xfer(8'h05, 3'h0, 32'h0, 4'h1);
		check("sr1", rx_reg[7:0], 16'h08);
		xfer(8'h66, 3'h0, 32'h0, 4'h0);
		xfer(8'h99, 3'h0, 32'h0, 4'h0);
		xfer(8'h05, 3'h0, 32'h0, 4'h1);
		check("sr1", rx_reg[7:0], 16'h1c);
		xfer(8'hc0, 3'h1, 32'ha5000000, 4'h0);
		check("param", read_parameter_byte, 16'ha5);
		xfer(8'h0c, 3'h4, 32'h0, 4'h0);
		check("wrap", wrap_length_field, 16'h5);
		xfer(8'heb, 3'h4, 32'h00123400, 4'h0);
		check("mode", wire_reg, 16'hf0);
		xfer(8'h06, 3'h0, 32'h0, 4'h0);
		xfer(8'h31, 3'h1, 32'h00000000, 4'h0);
		check("quad", quad_enable_bit, 16'h1);
		check("latch", write_enable_latch, 16'h0);
		xfer(8'h06, 3'h0, 32'h0, 4'h0);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		check("latch", write_enable_latch, 16'h0);
		close_out();
	end
endmodule : testbench
